//--- bcr_pkg.sv
package bcr_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SEL_W  = 2;
  localparam int unsigned NUM_RES = 4;
  localparam int unsigned CRC_W  = 16;

  // Documented register offsets (byte addresses).
  localparam logic [7:0] OFS_SWAP_DATA    = 8'h0c;
  localparam logic [7:0] OFS_SWAP_COMPARE = 8'h10;
  localparam logic [7:0] OFS_SWAP_CONTROL = 8'h14;
  localparam logic [7:0] OFS_ROM_HEADER   = 8'h18;
  localparam logic [7:0] OFS_BUS_NAME     = 8'h1c;

  // Additional registers that load operands, report status, and hold the interrupt mask and link control.
  localparam logic [7:0] OFS_DATA_LOAD    = 8'h40;
  localparam logic [7:0] OFS_COMPARE_LOAD = 8'h44;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h48;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h4c;
  localparam logic [7:0] OFS_LINK_CTRL    = 8'h50;
  localparam logic [7:0] OFS_OLD_VALUE    = 8'h54;
  localparam logic [7:0] OFS_BLOCK_STATUS = 8'h58;

  // Field positions.
  localparam int unsigned DONE_BIT      = 31;
  localparam int unsigned INFO_LEN_LSB  = 24;
  localparam int unsigned CRC_LEN_LSB   = 16;
  localparam int unsigned IRQ_SWAP_BIT  = 0;
  localparam int unsigned IRQ_LOAD_BIT  = 1;
  localparam int unsigned IRQ_W         = 2;
  localparam int unsigned LINK_EN_BIT   = 0;
  localparam int unsigned ST_PRESENT    = 0;
  localparam int unsigned ST_LOADED     = 1;
  localparam int unsigned ST_MATCH      = 2;

  // Values after reset.
  localparam logic [31:0] BUS_NAME_VALUE   = 32'h31333934;
  localparam logic        DONE_RESET       = 1'b1;
  localparam logic [1:0]  SEL_RESET        = 2'h0;
  localparam logic [31:0] HEADER_RESET     = 32'h00000000;
  localparam logic [31:0] OPERAND_RESET    = 32'h00000000;
  localparam logic [31:0] RESOURCE_RESET   = 32'h00000000;

  // Serial EEPROM clock timing.
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned EEP_HALF_NS      = 5000;
  localparam int unsigned EEP_HALF_CYC     = EEP_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned EEP_CNT_W        = 16;

  typedef enum logic [1:0] {
    BCR_RES_BUS_MANAGER_ID,
    BCR_RES_BANDWIDTH_AVAILABLE,
    BCR_RES_CHANNELS_AVAILABLE_HI,
    BCR_RES_CHANNELS_AVAILABLE_LO
  } bcr_res_sel_t;

endpackage : bcr_pkg

//--- bcr_if.sv
`timescale 1ns/100ps
`default_nettype none

interface bcr_swap_if;
  logic        start;
  logic [1:0]  sel;
  logic [31:0] cmp;
  logic [31:0] swp;
  logic        done;
  logic        match;
  logic [31:0] old;

  modport ctrl   (output start, sel, cmp, swp, input done, match, old);
  modport engine (input start, sel, cmp, swp, output done, match, old);
endinterface : bcr_swap_if

interface bcr_eep_if;
  logic        start;
  logic        sdata;
  logic        sclk;
  logic        done;
  logic [15:0] crc;

  modport ctrl   (output start, sdata, input sclk, done, crc);
  modport loader (input start, sdata, output sclk, done, crc);
endinterface : bcr_eep_if

`default_nettype wire

//--- bcr_swap_engine.sv
`timescale 1ns/100ps
`default_nettype none

module bcr_swap_engine
  import bcr_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   srst,
  input  wire logic   ce,
  bcr_swap_if.engine  sw
);

  logic [31:0] res_q [NUM_RES];
  logic        hit;

  assign hit = (res_q[sw.sel] == sw.cmp);

  // Each resource is replaced only on a matching compare.
  for (genvar i = 0; i < NUM_RES; i++) begin : g_res
    always_ff @(posedge core_clk) begin
      if (srst) begin
        res_q[i] <= RESOURCE_RESET;
      end else if (ce && sw.start && hit && (sw.sel == SEL_W'(i))) begin
        res_q[i] <= sw.swp;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sw.done  <= 1'b0;
      sw.match <= 1'b0;
      sw.old   <= OPERAND_RESET;
    end else if (ce) begin
      sw.done <= sw.start;
      if (sw.start) begin
        sw.match <= hit;
        sw.old   <= res_q[sw.sel];
      end
    end
  end

endmodule : bcr_swap_engine

`default_nettype wire

//--- bcr_eep_loader.sv
`timescale 1ns/100ps
`default_nettype none

module bcr_eep_loader
  import bcr_pkg::*;
#(
  parameter int unsigned HALF_CYC = EEP_HALF_CYC
) (
  input  wire logic   core_clk,
  input  wire logic   srst,
  input  wire logic   ce,
  bcr_eep_if.loader   ep
);

  typedef enum logic [1:0] {BCR_LD_IDLE, BCR_LD_SHIFT, BCR_LD_DONE} bcr_ld_t;

  bcr_ld_t                  state_q;
  logic [EEP_CNT_W-1:0]     div_q;
  logic [4:0]               bit_q;
  logic                     tick;

  assign tick = (div_q == EEP_CNT_W'(HALF_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= BCR_LD_IDLE;
      div_q   <= '0;
      bit_q   <= '0;
      ep.sclk <= 1'b0;
      ep.crc  <= 16'h0000;
      ep.done <= 1'b0;
    end else if (ce) begin
      ep.done <= 1'b0;
      unique case (state_q)
        BCR_LD_IDLE: begin
          if (ep.start) begin
            state_q <= BCR_LD_SHIFT;
            div_q   <= '0;
            bit_q   <= '0;
          end
        end
        BCR_LD_SHIFT: begin
          div_q <= tick ? '0 : div_q + 1'b1;
          if (tick) begin
            ep.sclk <= ~ep.sclk;
            // Data is taken as the serial clock rises, MSB first.
            if (!ep.sclk) begin
              ep.crc <= {ep.crc[14:0], ep.sdata};
              bit_q  <= bit_q + 1'b1;
              if (bit_q == 5'(CRC_W - 1)) begin
                state_q <= BCR_LD_DONE;
                ep.done <= 1'b1;
              end
            end
          end
        end
        BCR_LD_DONE: begin
          ep.sclk <= 1'b0;
        end
        default: begin
          state_q <= BCR_LD_IDLE;
        end
      endcase
    end
  end

endmodule : bcr_eep_loader

`default_nettype wire

//--- bcr_top.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none

module bcr_top
  import bcr_pkg::*;
#(
  parameter int unsigned EEP_HALF = EEP_HALF_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              eep_present_pin,
  input  wire logic              eep_data_pin,
  output logic                   eep_clk_pin,
  output logic                   link_active_enable,
  output logic      [31:0]       rom_header_quadlet,
  output logic      [31:0]       bus_info_quadlet0,
  output logic                   irq
);

  bcr_swap_if sw ();
  bcr_eep_if  ep ();

  // APB decode.
  logic        acc_phase;
  logic        wr_commit;
  logic        addr_hit;
  logic [31:0] rd_word;
  logic        wr_ctrl;
  logic        wr_hdr;
  logic        wr_link;
  logic        wr_stat;
  logic        wr_mask;
  logic        wr_data;
  logic        wr_cmp;

  // Register state.
  logic [31:0]       data_q;
  logic [31:0]       compare_q;
  logic              swap_complete_flag_q;
  logic [1:0]        resource_select_q;
  logic              start_q;
  logic [15:0]       len_bytes_q;
  logic [15:0]       crc_q;
  logic [IRQ_W-1:0]  irq_status_q;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [IRQ_W-1:0]  irq_event;
  logic              link_en_q;
  logic              loaded_q;

  // Pin synchronisers and strap capture.
  logic pres_s1_q;
  logic pres_s2_q;
  logic data_s1_q;
  logic data_s2_q;
  logic strap_taken_q;
  logic present_q;
  logic load_start_q;

  assign acc_phase = psel & penable & ~pready;
  assign wr_commit = psel & penable & pready & pwrite;

  // One strobe per writable register, high only in the commit cycle.
  assign wr_ctrl = wr_commit & (paddr == OFS_SWAP_CONTROL);
  assign wr_hdr  = wr_commit & (paddr == OFS_ROM_HEADER);
  assign wr_link = wr_commit & (paddr == OFS_LINK_CTRL);
  assign wr_stat = wr_commit & (paddr == OFS_IRQ_STATUS);
  assign wr_mask = wr_commit & (paddr == OFS_IRQ_MASK);
  assign wr_data = wr_commit & (paddr == OFS_DATA_LOAD);
  assign wr_cmp  = wr_commit & (paddr == OFS_COMPARE_LOAD);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pres_s1_q <= 1'b0;
      pres_s2_q <= 1'b0;
      data_s1_q <= 1'b0;
      data_s2_q <= 1'b0;
    end else if (ce) begin
      pres_s1_q <= eep_present_pin;
      pres_s2_q <= pres_s1_q;
      data_s1_q <= eep_data_pin;
      data_s2_q <= data_s1_q;
    end
  end

  // The strap is sampled once, after the synchroniser has filled.
  logic [1:0] settle_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      settle_q      <= 2'h0;
      strap_taken_q <= 1'b0;
      present_q     <= 1'b0;
      load_start_q  <= 1'b0;
    end else if (ce) begin
      load_start_q <= 1'b0;
      if (settle_q != 2'h3) begin
        settle_q <= settle_q + 2'h1;
      end else if (!strap_taken_q) begin
        strap_taken_q <= 1'b1;
        present_q     <= pres_s2_q;
        load_start_q  <= pres_s2_q;
      end
    end
  end

  assign ep.start = load_start_q;
  assign ep.sdata = data_s2_q;

  bcr_eep_loader #(
    .HALF_CYC (EEP_HALF)
  ) u_loader (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (ce),
    .ep       (ep)
  );

  assign sw.start = start_q;
  assign sw.sel   = resource_select_q;
  assign sw.cmp   = compare_q;
  assign sw.swp   = data_q;

  bcr_swap_engine u_engine (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (ce),
    .sw       (sw)
  );

  // Read multiplexer.
  always_comb begin
    rd_word  = 32'h00000000;
    addr_hit = 1'b1;
    unique case (paddr)
      OFS_SWAP_DATA:    rd_word = data_q;
      OFS_SWAP_COMPARE: rd_word = compare_q;
      OFS_SWAP_CONTROL: begin
        rd_word[DONE_BIT]  = swap_complete_flag_q;
        rd_word[1:0]       = resource_select_q;
      end
      OFS_ROM_HEADER:   rd_word = {len_bytes_q, crc_q};
      OFS_BUS_NAME:     rd_word = BUS_NAME_VALUE;
      OFS_DATA_LOAD:    rd_word = data_q;
      OFS_COMPARE_LOAD: rd_word = compare_q;
      OFS_IRQ_STATUS:   rd_word[IRQ_W-1:0] = irq_status_q;
      OFS_IRQ_MASK:     rd_word[IRQ_W-1:0] = irq_mask_q;
      OFS_LINK_CTRL:    rd_word[LINK_EN_BIT] = link_en_q;
      OFS_OLD_VALUE:    rd_word = sw.old;
      OFS_BLOCK_STATUS: begin
        rd_word[ST_PRESENT] = present_q;
        rd_word[ST_LOADED]  = loaded_q;
        rd_word[ST_MATCH]   = sw.match;
      end
      default:          addr_hit = 1'b0;
    endcase
  end

  // APB slave answers one cycle into the access phase.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      pready  <= acc_phase;
      pslverr <= acc_phase & ~addr_hit;
      if (acc_phase && !pwrite) begin
        prdata <= rd_word;
      end else if (!acc_phase) begin
        prdata <= 32'h00000000;
      end
    end
  end

  // Operands for the compare-swap; visible to the host only as reads
  // at their documented offsets and at the load offsets.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_q    <= OPERAND_RESET;
      compare_q <= OPERAND_RESET;
    end else if (ce) begin
      if (wr_data) begin
        data_q <= pwdata;
      end
      if (wr_cmp) begin
        compare_q <= pwdata;
      end
    end
  end

  // Control register: select, launch and completion flag.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      resource_select_q    <= SEL_RESET;
      swap_complete_flag_q <= DONE_RESET;
      start_q              <= 1'b0;
    end else if (ce) begin
      start_q <= 1'b0;
      if (wr_ctrl) begin
        resource_select_q    <= pwdata[1:0];
        swap_complete_flag_q <= 1'b0;
        start_q              <= 1'b1;
      end
      // A finishing swap wins over a clearing write in the same cycle.
      if (sw.done) begin
        swap_complete_flag_q <= 1'b1;
      end
    end
  end

  // ROM header: the EEPROM load of the CRC field takes priority over a host write.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      len_bytes_q <= HEADER_RESET[31:16];
      crc_q       <= HEADER_RESET[15:0];
      loaded_q    <= 1'b0;
    end else if (ce) begin
      if (wr_hdr) begin
        len_bytes_q <= pwdata[31:16];
        crc_q       <= pwdata[15:0];
      end
      if (ep.done) begin
        crc_q    <= ep.crc;
        loaded_q <= 1'b1;
      end
    end
  end

  // Link enable; software orders header setup before setting it.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      link_en_q <= 1'b0;
    end else if (ce && wr_link) begin
      link_en_q <= pwdata[LINK_EN_BIT];
    end
  end

  // Interrupt status is sticky, cleared by writing one; a new event
  // in the same cycle as its clear keeps the bit set.
  assign irq_event[IRQ_SWAP_BIT] = sw.done;
  assign irq_event[IRQ_LOAD_BIT] = ep.done;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_status_q <= '0;
      irq_mask_q   <= '0;
    end else if (ce) begin
      if (wr_stat) begin
        irq_status_q <= (irq_status_q & ~pwdata[IRQ_W-1:0]) | irq_event;
      end else begin
        irq_status_q <= irq_status_q | irq_event;
      end
      if (wr_mask) begin
        irq_mask_q <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // Registered outputs toward the link and the interrupt controller.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq                <= 1'b0;
      link_active_enable <= 1'b0;
      rom_header_quadlet <= HEADER_RESET;
      bus_info_quadlet0  <= BUS_NAME_VALUE;
    end else if (ce) begin
      irq                <= |(irq_status_q & irq_mask_q);
      link_active_enable <= link_en_q;
      rom_header_quadlet <= {len_bytes_q, crc_q};
      bus_info_quadlet0  <= BUS_NAME_VALUE;
    end
  end

  assign eep_clk_pin = ep.sclk;

endmodule : bcr_top

`default_nettype wire

//--- bcr_top_sva.sv
`timescale 1ns/100ps
`default_nettype none

module bcr_top_sva
  import bcr_pkg::*;
#(
  parameter int unsigned EEP_HALF = EEP_HALF_CYC
) (
  input wire logic              core_clk,
  input wire logic              srst,
  input wire logic              ce,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              eep_present_pin,
  input wire logic              eep_data_pin,
  input wire logic              eep_clk_pin,
  input wire logic              link_active_enable,
  input wire logic [31:0]       rom_header_quadlet,
  input wire logic [31:0]       bus_info_quadlet0,
  input wire logic              irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst || !ce);

  sequence setup_s(logic [7:0] a, logic w);
    psel && !penable && paddr == a && pwrite == w;
  endsequence
  sequence commit_s(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  one_wait_a: assert property (psel && !penable |-> ##2 pready)
    else $error("answer not two cycles after setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside answer");
  idle_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  name_read_a: assert property (
    setup_s(OFS_BUS_NAME, 1'b0) |-> ##2 prdata == BUS_NAME_VALUE)
    else $error("bus name read wrong");
  ctrl_rsvd_a: assert property (
    setup_s(OFS_SWAP_CONTROL, 1'b0) |-> ##2 prdata[30:2] == 29'h0)
    else $error("control reserved bits set");
  info_const_a: assert property (
    bus_info_quadlet0 == BUS_NAME_VALUE)
    else $error("bus info quadlet wrong");
  hdr_port_a: assert property (
    commit_s(OFS_ROM_HEADER) |-> ##2 rom_header_quadlet == $past(pwdata, 2))
    else $error("header port not updated");
  link_copy_a: assert property (
    commit_s(OFS_LINK_CTRL) |->
      ##2 link_active_enable == $past(pwdata[0], 2))
    else $error("link enable not copied");
  done_clear_a: assert property (
    commit_s(OFS_SWAP_CONTROL) ##1 setup_s(OFS_SWAP_CONTROL, 1'b0)
      |-> ##2 !prdata[DONE_BIT])
    else $error("done flag not cleared by write");
endmodule : bcr_top_sva

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import bcr_pkg::*;
;
  logic        core_clk, srst, ce, psel, penable, pwrite;
  logic        eep_present_pin, eep_data_pin, clk_d, er, m;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rom_header_quadlet, bus_info_quadlet0;
  logic        pready, pslverr, eep_clk_pin, link_active_enable, irq;
  logic [31:0] r, d, c, res[4];
  logic [15:0] crc_e;
  int          miscompares, tests_run, seed, bit_i, n, s;

  bcr_top #(.EEP_HALF(4)) bcr_top_i (
    .core_clk(core_clk), .srst(srst), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eep_present_pin(eep_present_pin), .eep_data_pin(eep_data_pin),
    .eep_clk_pin(eep_clk_pin), .link_active_enable(link_active_enable),
    .rom_header_quadlet(rom_header_quadlet),
    .bus_info_quadlet0(bus_info_quadlet0), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One transfer, started right after a rising edge; leaves psel high.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
    int k;
    k = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      stop_test();
    end
    r = prdata;
    er = pslverr;
  endtask : xfer

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge core_clk);
    xfer(w, a, wd);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // A write followed at once by a read of the same register.
  task automatic wrrd(input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    xfer(1'b1, a, wd);
    xfer(1'b0, a, 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : wrrd

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, r, exp);
  endtask : rdc

  // Shifts the next check value bit once each serial clock rise is seen.
  always @(posedge core_clk) begin
    clk_d <= eep_clk_pin;
    if (eep_clk_pin === 1'b1 && clk_d === 1'b0 && bit_i < 15) begin
      bit_i        <= bit_i + 1;
      eep_data_pin <= crc_e[14 - bit_i];
    end
  end

  initial begin
    #400000;
    miscompares++;
    stop_test();
  end

  initial begin
    seed = 32'h0d8e1728;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    srst = 1'b1;
    eep_present_pin = 1'b1;
    crc_e = 16'($random(seed));
    eep_data_pin = crc_e[15];
    bit_i = 0;
    clk_d = 1'b0;
    res = '{default: 32'h0};
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    rdc("control", OFS_SWAP_CONTROL, 32'h80000000);
    apb(1'b1, OFS_SWAP_COMPARE, 32'hffffffff);
    apb(1'b1, OFS_BUS_NAME, 32'h0);
    rdc("compare", OFS_SWAP_COMPARE, 32'h0);
    rdc("busname", OFS_BUS_NAME, 32'h31333934);
    apb(1'b0, 8'hf0, 32'h0);
    chk("slverr", {31'h0, er}, 32'h1);
    n = 0;
    do begin
      apb(1'b0, OFS_BLOCK_STATUS, 32'h0);
      n++;
    end while (r[ST_LOADED] !== 1'b1 && n < 200);
    chk("status", r, 32'h3);
    rdc("header", OFS_ROM_HEADER, {16'h0, crc_e});
    chk("hdrport", rom_header_quadlet, {16'h0, crc_e});
    rdc("irqstat", OFS_IRQ_STATUS, 32'h2);
    chk("irqmask", {31'h0, irq}, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h3);
    repeat (3) @(posedge core_clk);
    chk("irqon", {31'h0, irq}, 32'h1);
    apb(1'b1, OFS_IRQ_STATUS, 32'h2);
    repeat (3) @(posedge core_clk);
    chk("irqoff", {31'h0, irq}, 32'h0);
    d = $random(seed);
    apb(1'b1, OFS_ROM_HEADER, d);
    rdc("hdrwr", OFS_ROM_HEADER, d);
    chk("hdrport", rom_header_quadlet, d);
    apb(1'b1, OFS_LINK_CTRL, 32'h1);
    repeat (3) @(posedge core_clk);
    chk("link", {31'h0, link_active_enable}, 32'h1);
    // Matches, then misses, then matches again on every resource.
    for (int p = 0; p < 12; p++) begin
      s = p % 4;
      m = (p < 4 || p >= 8);
      d = $random(seed);
      c = m ? res[s] : ~res[s];
      apb(1'b1, OFS_DATA_LOAD, d);
      apb(1'b1, OFS_COMPARE_LOAD, c);
      wrrd(OFS_SWAP_CONTROL, {1'b1, 29'($random(seed)), 2'(s)});
      chk("busy", r, 32'(s));
      n = 0;
      do begin
        apb(1'b0, OFS_SWAP_CONTROL, 32'h0);
        n++;
      end while (r[DONE_BIT] !== 1'b1 && n < 20);
      chk("done", r, 32'h80000000 | s);
      rdc("swapdata", OFS_SWAP_DATA, d);
      rdc("swapcmp", OFS_SWAP_COMPARE, c);
      rdc("oldval", OFS_OLD_VALUE, res[s]);
      rdc("match", OFS_BLOCK_STATUS, {29'h0, m, 2'h3});
      chk("swapirq", {31'h0, irq}, 32'h1);
      apb(1'b1, OFS_IRQ_STATUS, 32'h1);
      if (m) res[s] = d;
    end
    stop_test();
  end
endmodule : tb_top

bind bcr_top bcr_top_sva #(.EEP_HALF(EEP_HALF)) sva_i (
  .core_clk(core_clk), .srst(srst), .ce(ce), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .eep_present_pin(eep_present_pin), .eep_data_pin(eep_data_pin),
  .eep_clk_pin(eep_clk_pin), .link_active_enable(link_active_enable),
  .rom_header_quadlet(rom_header_quadlet),
  .bus_info_quadlet0(bus_info_quadlet0), .irq(irq));

`default_nettype wire
